// File: design/hppcr_regs.sv
`timescale 1ns/1ps
module hppcr_regs
    import hppcr_pkg::*;
#(
    parameter int OC_D0_CYC = OC_DELAY0_CYC,
    parameter int OC_D1_CYC = OC_DELAY1_CYC,
    parameter int OC_D2_CYC = OC_DELAY2_CYC,
    parameter int OC_D3_CYC = OC_DELAY3_CYC
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic LOCAL_POWER_SENSE_I,
    input wire logic WRITE_LOCK_SET_I,
    input wire logic ATTACH_SET_I,
    input wire logic ACK_DONE_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    output logic WRITE_REJECT_O,
    output logic CONFIG_WRITE_LOCK_O,
    output logic SELF_POWERED_O,
    output logic DYNAMIC_SWITCH_O,
    output logic FULL_SPEED_ONLY_O,
    output logic FRAME_END_PACKET_SUPPRESS_O,
    output logic OC_SENSE_GANGED_O,
    output logic OC_SENSE_NONE_O,
    output logic [OC_CNT_W-1:0] OC_DELAY_CYCLES_O,
    output logic COMPOUND_DEVICE_O,
    output logic [1:0] FIXED_DEVICE_MASK_O,
    output logic [1:0] PORT_OFF_O,
    output logic HUB_ATTACH_O,
    output logic SLAVE_POWER_DOWN_O
);

    // Delay counts must be nonzero and fit the output
    if (OC_D0_CYC < 1 || OC_D1_CYC < 1 || OC_D2_CYC < 1 || OC_D3_CYC < 1)
    begin : g_chk_min
        $error("over-current delay counts must be at least one");
    end
    if (OC_D3_CYC >= 2**OC_CNT_W || OC_D2_CYC >= 2**OC_CNT_W ||
        OC_D1_CYC >= 2**OC_CNT_W || OC_D0_CYC >= 2**OC_CNT_W)
    begin : g_chk_max
        $error("over-current delay counts exceed the output width");
    end

    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0] b_pwr;
    logic [DATA_W-1:0] b_dyn;
    logic lock_ff, nxt_lock;
    logic reject_ff, nxt_reject;
    hppcr_attach_e att_ff, nxt_att;
    logic in_lock_range;
    logic wr_ok;
    logic rd_ok;
    logic eff_self;
    logic [OC_CNT_W-1:0] oc_cnt;
    logic [OC_CNT_W-1:0] ocd_ff;
    logic self_ff, dyn_ff, fs_ff, eop_ff, gang_ff, none_ff, cmp_ff;
    logic [1:0] fix_ff, off_ff;

    assign b_pwr = regs[IDX_PWR_SPEED];
    assign b_dyn = regs[IDX_DYN_TIMER];

    // Access gating by lock and slave power state
    always_comb
    begin
        in_lock_range = (REG_ADDR_I >= OFS_LOCK_FIRST) &&
                        (REG_ADDR_I <= OFS_LOCK_LAST);
        wr_ok = REG_WR_I && !(lock_ff && in_lock_range) &&
                (att_ff != ATT_DOWN);
        rd_ok = REG_RD_I && (att_ff != ATT_DOWN);
    end

    hppcr_reg_store u_store (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .addr_i(REG_ADDR_I),
        .wdata_i(REG_WDATA_I),
        .wr_i(wr_ok),
        .rd_i(rd_ok),
        .rdata_o(REG_RDATA_O),
        .regs_o(regs)
    );

    // Lock, refusal flag and attach sequence
    always_comb
    begin
        nxt_lock = lock_ff | WRITE_LOCK_SET_I;
        nxt_reject = REG_WR_I && !wr_ok;
        nxt_att = att_ff;
        case (att_ff)
            ATT_IDLE:
                if (ATTACH_SET_I)
                begin
                    nxt_att = ATT_WAIT_ACK;
                end
            ATT_WAIT_ACK:
                if (ACK_DONE_I)
                begin
                    nxt_att = ATT_DOWN;
                end
            ATT_DOWN:
                nxt_att = ATT_DOWN;
            default:
                nxt_att = ATT_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lock_ff <= 1'b0;
            reject_ff <= 1'b0;
            att_ff <= ATT_IDLE;
        end
        else
        begin
            lock_ff <= nxt_lock;
            reject_ff <= nxt_reject;
            att_ff <= nxt_att;
        end
    end

    // Effective power source and delay decode
    always_comb
    begin
        if (b_dyn[BIT_DYNAMIC])
        begin
            eff_self = LOCAL_POWER_SENSE_I;
        end
        else
        begin
            eff_self = b_pwr[BIT_PWR_SRC];
        end
        case (b_dyn[BIT_OCD_HI:BIT_OCD_LO])
            2'h0: oc_cnt = OC_CNT_W'(OC_D0_CYC);
            2'h1: oc_cnt = OC_CNT_W'(OC_D1_CYC);
            2'h2: oc_cnt = OC_CNT_W'(OC_D2_CYC);
            2'h3: oc_cnt = OC_CNT_W'(OC_D3_CYC);
            default: oc_cnt = OC_CNT_W'(OC_D0_CYC);
        endcase
    end

    // Registered configuration outputs
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            self_ff <= 1'b0;
            dyn_ff <= 1'b0;
            fs_ff <= 1'b0;
            eop_ff <= 1'b0;
            gang_ff <= 1'b1;
            none_ff <= 1'b0;
            ocd_ff <= OC_CNT_W'(OC_D0_CYC);
            cmp_ff <= 1'b0;
            fix_ff <= 2'h0;
            off_ff <= 2'h0;
        end
        else
        begin
            self_ff <= eff_self;
            dyn_ff <= b_dyn[BIT_DYNAMIC];
            fs_ff <= b_pwr[BIT_FS_ONLY];
            eop_ff <= b_pwr[BIT_EOP_SUP];
            gang_ff <= (b_pwr[BIT_OC_MODE_HI:BIT_OC_MODE_LO] ==
                        OC_GANGED);
            none_ff <= b_pwr[BIT_OC_MODE_HI];
            ocd_ff <= oc_cnt;
            cmp_ff <= b_dyn[BIT_COMPOUND];
            fix_ff <= port_bits(regs[IDX_FIXED_MASK]);
            off_ff <= eff_self ? port_bits(regs[IDX_OFF_SELF]) :
                      port_bits(regs[IDX_OFF_BUS]);
        end
    end

    assign SELF_POWERED_O = self_ff;
    assign DYNAMIC_SWITCH_O = dyn_ff;
    assign FULL_SPEED_ONLY_O = fs_ff;
    assign FRAME_END_PACKET_SUPPRESS_O = eop_ff;
    assign OC_SENSE_GANGED_O = gang_ff;
    assign OC_SENSE_NONE_O = none_ff;
    assign OC_DELAY_CYCLES_O = ocd_ff;
    assign COMPOUND_DEVICE_O = cmp_ff;
    assign FIXED_DEVICE_MASK_O = fix_ff;
    assign PORT_OFF_O = off_ff;
    assign CONFIG_WRITE_LOCK_O = lock_ff;
    assign WRITE_REJECT_O = reject_ff;
    assign HUB_ATTACH_O = att_ff[0];
    assign SLAVE_POWER_DOWN_O = att_ff[1];

    // Checks on the configuration behaviour
    logic seen_clk_ff;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            seen_clk_ff <= 1'b0;
        end
        else
        begin
            seen_clk_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    property p_src_static;
        !b_dyn[BIT_DYNAMIC] |=> SELF_POWERED_O == $past(b_pwr[BIT_PWR_SRC]);
    endproperty
    a_src_static: assert property (p_src_static)
        else $error("power source not taken from stored bit");

    property p_src_dynamic;
        b_dyn[BIT_DYNAMIC] |=> SELF_POWERED_O == $past(LOCAL_POWER_SENSE_I);
    endproperty
    a_src_dynamic: assert property (p_src_dynamic)
        else $error("power source not taken from sense pin");

    property p_dyn_flag;
        1'b1 |=> DYNAMIC_SWITCH_O == $past(b_dyn[BIT_DYNAMIC]);
    endproperty
    a_dyn_flag: assert property (p_dyn_flag)
        else $error("dynamic switching flag wrong");

    property p_speed_eop;
        1'b1 |=> FULL_SPEED_ONLY_O == $past(b_pwr[BIT_FS_ONLY]) &&
            FRAME_END_PACKET_SUPPRESS_O == $past(b_pwr[BIT_EOP_SUP]);
    endproperty
    a_speed_eop: assert property (p_speed_eop)
        else $error("speed or frame end setting wrong");

    property p_oc_mode;
        1'b1 |=> OC_SENSE_NONE_O == $past(b_pwr[BIT_OC_MODE_HI]) &&
            OC_SENSE_GANGED_O == ($past(b_pwr[2:1]) == 2'h0);
    endproperty
    a_oc_mode: assert property (p_oc_mode)
        else $error("over-current sense decode wrong");

    property p_oc_delay;
        (b_dyn[5:4] == 2'h3) |=> OC_DELAY_CYCLES_O == OC_CNT_W'(OC_D3_CYC);
    endproperty
    a_oc_delay: assert property (p_oc_delay)
        else $error("longest over-current delay wrong");

    property p_compound;
        1'b1 |=> COMPOUND_DEVICE_O == $past(b_dyn[BIT_COMPOUND]);
    endproperty
    a_compound: assert property (p_compound)
        else $error("compound flag wrong");

    sequence s_wr_fixed;
        wr_ok && REG_ADDR_I == OFS_FIXED_MASK;
    endsequence
    sequence s_rd_fixed;
        rd_ok && REG_ADDR_I == OFS_FIXED_MASK && !REG_WR_I;
    endsequence
    property p_fixed_rdback;
        s_wr_fixed ##1 s_rd_fixed |=>
            REG_RDATA_O == ($past(REG_WDATA_I, 2) & 8'h06);
    endproperty
    a_fixed_rdback: assert property (p_fixed_rdback)
        else $error("fixed-device mask read back wrong");

    property p_bus_rsvd;
        (rd_ok && REG_ADDR_I == OFS_OFF_BUS) |=> (REG_RDATA_O & 8'hF9) == 8'h0;
    endproperty
    a_bus_rsvd: assert property (p_bus_rsvd)
        else $error("reserved disable mask bits not zero");

    property p_port_off;
        1'b1 |=> PORT_OFF_O == ($past(eff_self) ?
            $past(port_bits(regs[IDX_OFF_SELF])) :
            $past(port_bits(regs[IDX_OFF_BUS])));
    endproperty
    a_port_off: assert property (p_port_off)
        else $error("port disable mask not following power source");

    property p_reset_zero;
        !seen_clk_ff |-> regs == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not zero after reset");

    property p_lock_hold;
        (lock_ff && REG_WR_I && in_lock_range) |=> $stable(regs) &&
            WRITE_REJECT_O;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("write accepted while locked");

    sequence s_attach;
        !HUB_ATTACH_O && ATTACH_SET_I;
    endsequence
    property p_attach;
        s_attach |=> HUB_ATTACH_O && !SLAVE_POWER_DOWN_O;
    endproperty
    a_attach: assert property (p_attach)
        else $error("attach not signalled");

    property p_pdown;
        (HUB_ATTACH_O && ACK_DONE_I) |=> SLAVE_POWER_DOWN_O [*2];
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("slave not powered down after acknowledge");

endmodule // hppcr_regs

// File: design/hppcr_pkg.sv
package hppcr_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 5;

    // Register offsets
    localparam logic [7:0] OFS_PWR_SPEED = 8'h07;
    localparam logic [7:0] OFS_DYN_TIMER = 8'h08;
    localparam logic [7:0] OFS_FIXED_MASK = 8'h09;
    localparam logic [7:0] OFS_OFF_SELF = 8'h0A;
    localparam logic [7:0] OFS_OFF_BUS = 8'h0B;

    // Range covered by the configuration write lock
    localparam logic [7:0] OFS_LOCK_FIRST = 8'h01;
    localparam logic [7:0] OFS_LOCK_LAST = 8'h10;

    // Store slot of each register
    localparam logic [2:0] IDX_PWR_SPEED = 3'h0;
    localparam logic [2:0] IDX_DYN_TIMER = 3'h1;
    localparam logic [2:0] IDX_FIXED_MASK = 3'h2;
    localparam logic [2:0] IDX_OFF_SELF = 3'h3;
    localparam logic [2:0] IDX_OFF_BUS = 3'h4;

    // Reset value of every register
    localparam logic [7:0] RST_VAL = 8'h00;

    // Writable bits, reserved bits stay zero
    localparam logic [7:0] WMASK [NUM_REGS] =
        '{8'hAE, 8'hB8, 8'h06, 8'h06, 8'h06};

    // Field positions
    localparam int BIT_PWR_SRC = 7;
    localparam int BIT_FS_ONLY = 5;
    localparam int BIT_EOP_SUP = 3;
    localparam int BIT_OC_MODE_HI = 2;
    localparam int BIT_OC_MODE_LO = 1;
    localparam int BIT_DYNAMIC = 7;
    localparam int BIT_OCD_HI = 5;
    localparam int BIT_OCD_LO = 4;
    localparam int BIT_COMPOUND = 3;
    localparam int BIT_PORT2 = 2;
    localparam int BIT_PORT1 = 1;

    // Over-current sense encodings
    localparam logic [1:0] OC_GANGED = 2'h0;
    localparam logic [1:0] OC_RSVD = 2'h1;

    // Over-current delay times and clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int OC_DELAY0_NS = 100000;
    localparam int OC_DELAY1_NS = 2000000;
    localparam int OC_DELAY2_NS = 4000000;
    localparam int OC_DELAY3_NS = 6000000;
    localparam int OC_DELAY0_CYC = OC_DELAY0_NS / CLK_PERIOD_NS;
    localparam int OC_DELAY1_CYC = OC_DELAY1_NS / CLK_PERIOD_NS;
    localparam int OC_DELAY2_CYC = OC_DELAY2_NS / CLK_PERIOD_NS;
    localparam int OC_DELAY3_CYC = OC_DELAY3_NS / CLK_PERIOD_NS;
    localparam int OC_CNT_W = 20;

    // Attach sequence states; bit 0 is attach, bit 1 is power-down
    typedef enum logic [1:0] {
        ATT_IDLE = 2'b00,
        ATT_WAIT_ACK = 2'b01,
        ATT_DOWN = 2'b11
    } hppcr_attach_e;

    // Port pair of a port mask byte
    function automatic logic [1:0] port_bits(input logic [7:0] b);
        return {b[BIT_PORT2], b[BIT_PORT1]};
    endfunction

endpackage

// File: design/hppcr_reg_store.sv
`timescale 1ns/1ps
module hppcr_reg_store
    import hppcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic [NUM_REGS-1:0][DATA_W-1:0] regs_o
);

    logic [DATA_W-1:0] mem_ff [NUM_REGS];
    logic [DATA_W-1:0] nxt_mem [NUM_REGS];
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic hit;
    logic [2:0] idx;

    // Slot decode of an address
    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        return 3'(a - OFS_PWR_SPEED);
    endfunction

    assign hit = (addr_i >= OFS_PWR_SPEED) && (addr_i <= OFS_OFF_BUS);
    assign idx = reg_idx(addr_i);

    // Next contents and read data
    always_comb
    begin
        nxt_mem = mem_ff;
        nxt_rdata = rdata_ff;
        if (wr_i && hit)
        begin
            nxt_mem[idx] = wdata_i & WMASK[idx];
        end
        if (rd_i)
        begin
            nxt_rdata = hit ? mem_ff[idx] : RST_VAL;
        end
    end

    // Storage, all zero after reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                mem_ff[i] <= RST_VAL;
            end
            rdata_ff <= RST_VAL;
        end
        else
        begin
            mem_ff <= nxt_mem;
            rdata_ff <= nxt_rdata;
        end
    end

    // Contents seen by the hub logic
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            regs_o[i] = mem_ff[i];
        end
    end

    assign rdata_o = rdata_ff;

endmodule // hppcr_reg_store

// File: verification/hppcr_host_model.sv
`timescale 1ns/1ps
// Configuring host on the register port of the hub
module hppcr_host_model
    import hppcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // Idle port at time zero
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Byte the host is allowed to send to a register
    function automatic logic [7:0] legal(input logic [7:0] a,
        input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == OFS_PWR_SPEED && v[7])
            v[2] = 1'b0;
        if ((a == OFS_OFF_SELF || a == OFS_OFF_BUS) && v[1])
            v[2] = 1'b1;
        return v;
    endfunction

    // One byte write; lines toggle once released
    task automatic write(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] sent);
        sent = legal(a, d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= sent;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~sent;
    endtask

    // Write, then read of the same register in the next cycle
    task automatic write_read(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] sent, output logic [7:0] got);
        sent = legal(a, d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= sent;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~sent;
        #1;
        got = rdata_i;
    endtask

    // One byte read, data taken after the strobe edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule // hppcr_host_model

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench
    import hppcr_pkg::*;
;
    localparam int D[4] = '{5, 10, 20, 30};
    localparam logic [7:0] OFS[5] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B};
    localparam logic [7:0] WM[5] = '{8'hAE, 8'hB8, 8'h06, 8'h06, 8'h06};
    localparam logic [7:0] LA[4] = '{8'h01, 8'h07, 8'h10, 8'h11};
    logic clk = 1'b0, rst_n, sense, lock_set, att, ack;
    logic [7:0] addr, wdata, rdata, shadow[5], g, s;
    logic wr, rd, rej, lock, self_p, dyn, fs, eop, gang, none, comp;
    logic attached, pd;
    logic [1:0] fixed, poff;
    logic [19:0] dly;
    logic [31:0] rng, r;
    int error_cnt = 0, checks_done = 0, cyc_cnt = 0;

    always #5 clk = ~clk;

    hppcr_regs #(.OC_D0_CYC(5), .OC_D1_CYC(10), .OC_D2_CYC(20),
        .OC_D3_CYC(30)) u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .LOCAL_POWER_SENSE_I(sense),
        .WRITE_LOCK_SET_I(lock_set), .ATTACH_SET_I(att),
        .ACK_DONE_I(ack), .REG_RDATA_O(rdata), .WRITE_REJECT_O(rej),
        .CONFIG_WRITE_LOCK_O(lock), .SELF_POWERED_O(self_p),
        .DYNAMIC_SWITCH_O(dyn), .FULL_SPEED_ONLY_O(fs),
        .FRAME_END_PACKET_SUPPRESS_O(eop), .OC_SENSE_GANGED_O(gang),
        .OC_SENSE_NONE_O(none), .OC_DELAY_CYCLES_O(dly),
        .COMPOUND_DEVICE_O(comp), .FIXED_DEVICE_MASK_O(fixed),
        .PORT_OFF_O(poff), .HUB_ATTACH_O(attached),
        .SLAVE_POWER_DOWN_O(pd));

    hppcr_host_model u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    // Repeatable random source
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Expected decoded outputs from the shadow registers
    function automatic logic [10:0] exp_outs();
        logic sp;
        sp = shadow[1][7] ? sense : shadow[0][7];
        return {sp, shadow[1][7], shadow[0][5], shadow[0][3],
            shadow[0][2:1] == 2'b00, shadow[0][2], shadow[1][3],
            shadow[2][2:1], sp ? shadow[3][2:1] : shadow[4][2:1]};
    endfunction

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
            error_cnt++;
        end
    endtask

    // Decoded outputs after they settle
    task automatic check_outs();
        repeat (2) @(posedge clk);
        #1;
        chk({self_p, dyn, fs, eop, gang, none, comp, fixed, poff},
            exp_outs());
        chk(dly, D[shadow[1][5:4]]);
    endtask

    // Register write with shadow update, and read-back compare
    task automatic wreg(input int i, input logic [7:0] d);
        u_host.write(OFS[i], d, s);
        shadow[i] = s & WM[i];
    endtask
    task automatic rchk(input int i);
        u_host.read(OFS[i], g);
        chk(g, shadow[i]);
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        sense = 1'b0;
        lock_set = 1'b0;
        att = 1'b0;
        ack = 1'b0;
        rng = 32'h40;
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(i);
        check_outs();
        $display("test reset_values done");
        for (int c = 0; c < 4; c++)
        begin
            wreg(0, {5'h00, c[1:0], 1'b0});
            wreg(1, {2'b00, c[1:0], 4'h0});
            check_outs();
        end
        $display("test codes done");
        for (int n = 0; n < 40; n++)
        begin
            r = rnd();
            wreg(r[3:0] % 5, r[15:8]);
            @(posedge clk);
            sense <= r[16];
            rchk(r[3:0] % 5);
            check_outs();
            u_host.write_read(OFS[2], r[23:16], s, g);
            shadow[2] = s & WM[2];
            chk(g, shadow[2]);
        end
        $display("test random done");
        wreg(1, 8'h80);
        wreg(0, 8'h00);
        wreg(3, 8'h04);
        wreg(4, 8'h06);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            sense <= k[0];
            check_outs();
        end
        wreg(1, 8'h00);
        check_outs();
        u_host.write(8'h20, 8'hFF, s);
        u_host.read(8'h20, g);
        chk(g, 8'h00);
        $display("test dynamic done");
        @(posedge clk);
        lock_set <= 1'b1;
        @(posedge clk);
        lock_set <= 1'b0;
        #1;
        chk(lock, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            u_host.write(LA[k], 8'hA0, s);
            #1;
            chk(rej, LA[k] != 8'h11);
        end
        rchk(0);
        $display("test lock done");
        @(posedge clk);
        att <= 1'b1;
        @(posedge clk);
        att <= 1'b0;
        #1;
        chk({attached, pd}, 2'b10);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        #1;
        chk({attached, pd}, 2'b11);
        u_host.read(8'h09, g);
        chk(g, shadow[0]);
        u_host.write(8'h11, 8'h00, s);
        #1;
        chk(rej, 1'b1);
        $display("test attach done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (shadow[i]) shadow[i] = 8'h00;
        #1;
        chk({lock, attached, pd}, 3'b000);
        for (int i = 0; i < 5; i++) rchk(i);
        check_outs();
        $display("test second_reset done");
        test_done();
    end
endmodule // testbench
